// ---- design/scr_top.v ----
// Top of the system clock select and clock ready interrupt block.
// Assumes one 200 MHz clock, an Avalon-MM master and synchronous oscillator status inputs.
`timescale 1ns/10ps
`default_nettype none
`include "scr_map.vh"

// Notes on behaviour
// - Prescaler codes 1011 to 1111 give a bus clock enable every 16, 32, 64, 128 and 256 cycles.
// - Code 0000 enables every cycle, 0001 to 0111 divide by 2 to 8, and the field resets to 0010.
// - The status field in bits 3:2 mirrors the source really in use and never shows 11.
// - The select field in bits 1:0 picks fast, external or PLL, ignores 11 and resets to 0.
// - With clock security on, a return from Standby or Stop forces the fast internal source.
// - With clock security on, failure of an external system clock forces the fast internal source.
// - Writing 1 to bit 23 clears the clock failure flag and writing 0 does nothing.
// - Writing 1 to bits 20, 19, 18 and 16 clears the matching ready flag, writing 0 does nothing.
// - Bits 12, 11, 10 and 8 enable the PLL, external, fast and slow ready interrupts, reset 0.
// - With clock security on, bit 7 sets on external oscillator failure and stays set until software clears it.
// - Bit 4 sets when the PLL locks and holds until its clear bit is written.
// - Bit 3 sets when the external oscillator becomes ready and holds until cleared.
// - Bit 2 sets when the fast internal oscillator becomes ready and holds until cleared.
// - Bit 0 sets when the slow internal oscillator becomes ready and holds until cleared.
module scr_top (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Avalon-MM slave.
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Oscillator status, levels synchronous to clk.
    input wire pll_locked,
    input wire external_osc_ready,
    input wire internal_fast_osc_ready,
    input wire internal_slow_osc_ready,
    // Clock monitor and power events.
    input wire external_osc_fail,
    input wire wake_from_low_power,
    // Clock control outputs.
    output wire [1:0] system_clock_source_select,
    output wire bus_clk_en,
    // Clock interrupt request.
    output reg clk_irq
);

    // Bus access handshake state.
    reg ack_q;
    wire req;
    wire do_write;
    wire hit_cfg;
    wire hit_intr;

    // Configuration state.
    reg [3:0] bus_clock_prescaler_q;
    reg [3:0] bus_clock_prescaler_d;
    reg clock_security_enable_q;
    reg clock_security_enable_d;
    wire [1:0] system_clock_source_status;

    // Interrupt state.
    reg [7:0] flags_q;
    reg [7:0] flags_d;
    reg [4:0] irq_en_q;
    reg [4:0] irq_en_d;
    reg [7:0] set_ev;
    reg [7:0] clr_ev;
    reg [3:0] ready_prev_q;
    reg fail_prev_q;
    wire fail_pulse;
    wire [7:0] en_map;
    wire [31:0] cfg_word;
    wire [31:0] intr_word;

    // Merges write data into a byte lane only where its byte enable is set.
    function [7:0] scr_lane;
        input [7:0] old;
        input [7:0] neu;
        input be;
        begin
            scr_lane = be ? neu : old;
        end
    endfunction

    assign req = avs_read | avs_write;
    assign hit_cfg = (avs_address == `SCR_OFS_CLOCK_CONFIG);
    assign hit_intr = (avs_address == `SCR_OFS_CLOCK_INTERRUPT_CONTROL);
    // The write acts at the edge where the master sees waitrequest low.
    assign do_write = avs_write & ack_q;

    // One wait state: waitrequest drops for one cycle after a request is seen.
    // Registering the answer keeps every bus output straight off a flip-flop.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            if (req && !ack_q) begin
                ack_q <= 1'b1;
                avs_waitrequest <= 1'b0;
                if (avs_read && hit_cfg) begin
                    avs_readdata <= cfg_word;
                end else if (avs_read && hit_intr) begin
                    avs_readdata <= intr_word;
                end else begin
                    avs_readdata <= 32'h00000000;
                end
            end else begin
                ack_q <= 1'b0;
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // Readback words; reserved bits and write-only clear bits read as zero.
    // reserved read zero
    assign cfg_word = {23'h000000, clock_security_enable_q, bus_clock_prescaler_q,
        system_clock_source_status, system_clock_source_select};
    assign intr_word = {19'h00000, irq_en_q, flags_q};

    // Configuration register writes, lane by lane.
    always @* begin
        bus_clock_prescaler_d = bus_clock_prescaler_q;
        clock_security_enable_d = clock_security_enable_q;
        if (do_write && hit_cfg && avs_byteenable[0]) begin
            bus_clock_prescaler_d = avs_writedata[`SCR_CFG_PRESCALER_LSB +: 4];
        end
        if (do_write && hit_cfg && avs_byteenable[1]) begin
            clock_security_enable_d = avs_writedata[`SCR_CFG_SECURITY_ENABLE_BIT];
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_clock_prescaler_q <= `SCR_PRESCALER_RESET;
            clock_security_enable_q <= 1'b0;
        end else begin
            bus_clock_prescaler_q <= bus_clock_prescaler_d;
            clock_security_enable_q <= clock_security_enable_d;
        end
    end

    // Divider for the bus clock enable.
    scr_prescaler #(
        .CNT_W(8)
    ) u_prescaler (
        .clk(clk),
        .rst(rst),
        .code(bus_clock_prescaler_q),
        .bus_clk_en_q(bus_clk_en)
    );

    // Source select with its status mirror and fallback.
    scr_src_switch u_src_switch (
        .clk(clk),
        .rst(rst),
        .sel_we(do_write & hit_cfg & avs_byteenable[0]),
        .sel_wdata(avs_writedata[`SCR_CFG_SELECT_LSB +: 2]),
        .security_en(clock_security_enable_q),
        .wake_pulse(wake_from_low_power),
        .ext_fail_pulse(fail_pulse),
        .ext_ready(external_osc_ready),
        .pll_ready(pll_locked),
        .sel_q(system_clock_source_select),
        .status_q(system_clock_source_status)
    );

    // Previous levels for rising-edge detection of the ready and failure inputs.
    // Inputs are synchronous, so no synchroniser sits in front of these flops.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_prev_q <= 4'h0;
            fail_prev_q <= 1'b0;
        end else begin
            ready_prev_q <= {pll_locked, external_osc_ready, internal_fast_osc_ready,
                internal_slow_osc_ready};
            fail_prev_q <= external_osc_fail;
        end
    end

    // The monitor only reports failure while clock security is switched on.
    assign fail_pulse = external_osc_fail & ~fail_prev_q & clock_security_enable_q;

    // Hardware set events, placed at the flag positions.
    always @* begin
        set_ev = 8'h00;
        set_ev[`SCR_INT_SLOW_READY_FLAG_BIT] = internal_slow_osc_ready & ~ready_prev_q[0];
        set_ev[`SCR_INT_FAST_READY_FLAG_BIT] = internal_fast_osc_ready & ~ready_prev_q[1];
        set_ev[`SCR_EXT_READY_FLAG_BIT] = external_osc_ready & ~ready_prev_q[2];
        set_ev[`SCR_PLL_READY_FLAG_BIT] = pll_locked & ~ready_prev_q[3];
        set_ev[`SCR_CLOCK_FAILURE_FLAG_BIT] = fail_pulse;
    end

    // Software clear events; clear bits sit sixteen above their flags.
    always @* begin
        clr_ev = 8'h00;
        if (do_write && hit_intr && avs_byteenable[2]) begin
            clr_ev = avs_writedata[`SCR_READY_CLEAR_SHIFT +: 8] & `SCR_READY_MASK;
            clr_ev[`SCR_CLOCK_FAILURE_FLAG_BIT] = avs_writedata[`SCR_CLOCK_FAILURE_CLEAR_BIT];
        end
    end

    // Sticky flags: a set in the clearing cycle wins, so no event is lost.
    always @* begin
        flags_d = (flags_q & ~clr_ev) | set_ev;
    end

    // Interrupt enables, one per ready flag.
    // ready irq enables
    always @* begin
        irq_en_d = irq_en_q;
        if (do_write && hit_intr && avs_byteenable[1]) begin
            irq_en_d = avs_writedata[`SCR_READY_ENABLE_SHIFT +: 5] & 5'h1d;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_q <= 8'h00;
            irq_en_q <= 5'h00;
        end else begin
            flags_q <= flags_d;
            irq_en_q <= irq_en_d;
        end
    end

    // Enables laid over the flag positions; the failure flag is never masked.
    assign en_map = {1'b1, 2'h0, irq_en_q};

    // Registered request, in step with the flags it reflects, since it is built from flags_d.
    // interrupt request
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_irq <= 1'b0;
        end else begin
            clk_irq <= |(flags_d & en_map);
        end
    end

endmodule // scr_top

`default_nettype wire

// ---- common/scr_map.vh ----
// Constants of the system clock select and clock ready interrupt block.
// Assumes it is included by bare name from design files; holds definitions only.
`ifndef SCR_MAP_VH
`define SCR_MAP_VH

// Register byte offsets on the register bus.
`define SCR_OFS_CLOCK_CONFIG 4'h0
`define SCR_OFS_CLOCK_INTERRUPT_CONTROL 4'h4

// Clock configuration register fields.
`define SCR_CFG_SELECT_LSB 0
`define SCR_CFG_STATUS_LSB 2
`define SCR_CFG_PRESCALER_LSB 4
`define SCR_CFG_SECURITY_ENABLE_BIT 8

// Reset values.
`define SCR_PRESCALER_RESET 4'h2
`define SCR_SELECT_RESET 2'h0
`define SCR_INTR_RESET 32'h00000000

// Source codes shared by the select and status fields.
`define SCR_SRC_INTERNAL_FAST 2'h0
`define SCR_SRC_EXTERNAL 2'h1
`define SCR_SRC_PLL 2'h2
`define SCR_SRC_NONE 2'h3

// Clock interrupt control register: flags.
`define SCR_INT_SLOW_READY_FLAG_BIT 0
`define SCR_INT_FAST_READY_FLAG_BIT 2
`define SCR_EXT_READY_FLAG_BIT 3
`define SCR_PLL_READY_FLAG_BIT 4
`define SCR_CLOCK_FAILURE_FLAG_BIT 7

// Clock interrupt control register: enables and clear bits.
`define SCR_READY_ENABLE_SHIFT 8
`define SCR_READY_CLEAR_SHIFT 16
`define SCR_CLOCK_FAILURE_CLEAR_BIT 23

// Ready flag positions within the low byte (slow, fast, external, pll).
`define SCR_READY_MASK 8'h1d

`endif

// ---- design/scr_prescaler.v ----
// Bus clock prescaler: turns the four-bit divide code into a one-cycle enable.
// Assumes one clock (the system clock) and an asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module scr_prescaler #(
    parameter CNT_W = 8
) (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Divide code from the configuration register.
    input wire [3:0] code,
    // Bus clock enable, one cycle in every divide period.
    output reg bus_clk_en_q
);

    // Terminal count (divide factor minus one) for every code.
    function [CNT_W-1:0] scr_div_last;
        input [3:0] c;
        begin
            case (c)
                4'h0: scr_div_last = 8'h00;
                4'h1: scr_div_last = 8'h01;
                4'h2: scr_div_last = 8'h02;
                4'h3: scr_div_last = 8'h03;
                4'h4: scr_div_last = 8'h04;
                4'h5: scr_div_last = 8'h05;
                4'h6: scr_div_last = 8'h06;
                4'h7: scr_div_last = 8'h07;
                4'h8: scr_div_last = 8'h01;
                4'h9: scr_div_last = 8'h03;
                4'ha: scr_div_last = 8'h03;
                4'hb: scr_div_last = 8'h0f;
                4'hc: scr_div_last = 8'h1f;
                4'hd: scr_div_last = 8'h3f;
                4'he: scr_div_last = 8'h7f;
                default: scr_div_last = 8'hff;
            endcase
        end
    endfunction

    reg [CNT_W-1:0] cnt_q;
    wire [CNT_W-1:0] last;
    wire at_last;

    assign last = scr_div_last(code);
    // A code change that lowers the factor below the count wraps at once.
    assign at_last = (cnt_q >= last);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= {CNT_W{1'b0}};
            bus_clk_en_q <= 1'b0;
        end else begin
            bus_clk_en_q <= at_last;
            if (at_last) begin
                cnt_q <= {CNT_W{1'b0}};
            end else begin
                cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // scr_prescaler

`default_nettype wire

// ---- design/scr_src_switch.v ----
// System clock source select register, its status mirror and the forced fallback.
// Assumes ready levels synchronous to clk and one-cycle wake and failure pulses.
`timescale 1ns/10ps
`default_nettype none
`include "scr_map.vh"

module scr_src_switch (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Software write of the select field.
    input wire sel_we,
    input wire [1:0] sel_wdata,
    // Fallback causes.
    input wire security_en,
    input wire wake_pulse,
    input wire ext_fail_pulse,
    // Source readiness.
    input wire ext_ready,
    input wire pll_ready,
    // Select register and source actually in use.
    output reg [1:0] sel_q,
    output reg [1:0] status_q
);

    wire force_fast;
    wire target_ready;

    assign force_fast = security_en &
        (wake_pulse | (ext_fail_pulse & (status_q == `SCR_SRC_EXTERNAL)));

    // A request for a source that is not running yet stays pending.
    assign target_ready = (sel_q == `SCR_SRC_INTERNAL_FAST) |
        ((sel_q == `SCR_SRC_EXTERNAL) & ext_ready) |
        ((sel_q == `SCR_SRC_PLL) & pll_ready);

    // Forced fallback beats a software write in the same cycle.
    // select field
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_q <= `SCR_SELECT_RESET;
            status_q <= `SCR_SRC_INTERNAL_FAST;
        end else if (force_fast) begin
            sel_q <= `SCR_SRC_INTERNAL_FAST;
            status_q <= `SCR_SRC_INTERNAL_FAST;
        end else begin
            if (sel_we && (sel_wdata != `SCR_SRC_NONE)) begin
                sel_q <= sel_wdata;
            end
            if (target_ready) begin
                status_q <= sel_q;
            end
        end
    end

endmodule // scr_src_switch

`default_nettype wire

// ---- sim/scr_checker.sv ----
// Checker for the clock select and clock ready interrupt block.
// Assumes it is bound to scr_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module scr_checker (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Register bus.
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Oscillator status and events.
    input wire pll_locked,
    input wire external_osc_ready,
    input wire internal_fast_osc_ready,
    input wire internal_slow_osc_ready,
    input wire external_osc_fail,
    input wire wake_from_low_power,
    // Clock control and interrupt.
    input wire [1:0] system_clock_source_select,
    input wire bus_clk_en,
    input wire clk_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Accepted writes, shadow of the security bit and rising inputs.
    logic sec_q;
    logic [4:0] in_q;
    wire acc = avs_write && !avs_waitrequest;
    wire acc_int = acc && avs_address == 4'h4;
    wire sel_wr = acc && avs_address == 4'h0 && avs_byteenable[0] && !wake_from_low_power;
    wire [4:0] in_now = {external_osc_fail, pll_locked, external_osc_ready,
        internal_fast_osc_ready, internal_slow_osc_ready};
    wire rise_any = |(in_now & ~in_q);
    wire rd_ans = avs_read && !avs_waitrequest;

    // Shadow state lets the fallback checks know when security is on.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sec_q <= 1'b0;
            in_q <= 5'h00;
        end else begin
            in_q <= in_now;
            if (acc && avs_address == 4'h0 && avs_byteenable[1]) begin
                sec_q <= avs_writedata[8];
            end
        end
    end

    sequence s_fail_event;
        sec_q && $rose(external_osc_fail);
    endsequence
    sequence s_irq_cause;
        $past(rise_any) || $past(acc_int) || $past(acc_int, 2);
    endsequence

    property p_sel_legal;
        system_clock_source_select != 2'h3;
    endproperty
    a_sel_legal: assert property (p_sel_legal) else $error("select shows code 11");
    property p_sel_wr;
        sel_wr && !external_osc_fail && avs_writedata[1:0] != 2'h3
            |=> system_clock_source_select == $past(avs_writedata[1:0]);
    endproperty
    a_sel_wr: assert property (p_sel_wr) else $error("select write lost");
    property p_sel_keep;
        sel_wr && avs_writedata[1:0] == 2'h3 |=> $stable(system_clock_source_select);
    endproperty
    a_sel_keep: assert property (p_sel_keep) else $error("select took code 11");
    property p_wake;
        sec_q && wake_from_low_power |=> system_clock_source_select == 2'h0;
    endproperty
    a_wake: assert property (p_wake) else $error("no fallback on wake");
    property p_fail_irq;
        s_fail_event |-> ##[1:2] clk_irq;
    endproperty
    a_fail_irq: assert property (p_fail_irq) else $error("no irq on failure");
    property p_irq_rise;
        $rose(clk_irq) |-> s_irq_cause;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_irq_fall;
        $fell(clk_irq) |-> $past(acc_int) || $past(acc_int, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
    property p_unmapped;
        rd_ans && avs_address != 4'h0 && avs_address != 4'h4 |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_int_rsv;
        rd_ans && avs_address == 4'h4 |-> (avs_readdata & 32'hffffe262) == 32'h0;
    endproperty
    a_int_rsv: assert property (p_int_rsv) else $error("reserved bits not zero");
endmodule // scr_checker

bind scr_top scr_checker i_scr_checker (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pll_locked(pll_locked),
    .external_osc_ready(external_osc_ready), .internal_fast_osc_ready(internal_fast_osc_ready),
    .internal_slow_osc_ready(internal_slow_osc_ready), .external_osc_fail(external_osc_fail),
    .wake_from_low_power(wake_from_low_power),
    .system_clock_source_select(system_clock_source_select), .bus_clk_en(bus_clk_en),
    .clk_irq(clk_irq));

`default_nettype wire

// ---- sim/test_system_clock_select_and_ready_irq.sv ----
// Self-checking bench for the clock select and clock ready interrupt block.
// Assumes scr_top with its checker bound; the bench is the bus master.
`timescale 1ns/10ps
`default_nettype none

module test_system_clock_select_and_ready_irq;
    logic clk, rst, avs_read, avs_write, bus_clk_en, clk_irq, avs_waitrequest;
    logic pll_locked, ext_rdy, fast_rdy, slow_rdy, ext_fail, wake;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic [1:0] sel;
    int errors = 0;
    int checks_done = 0;

    scr_top i_scr_top (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pll_locked(pll_locked),
        .external_osc_ready(ext_rdy), .internal_fast_osc_ready(fast_rdy),
        .internal_slow_osc_ready(slow_rdy), .external_osc_fail(ext_fail),
        .wake_from_low_power(wake), .system_clock_source_select(sel),
        .bus_clk_en(bus_clk_en), .clk_irq(clk_irq));

    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic finish_test;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One Avalon transfer; a fresh edge first so a request never restarts in the release step.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        repeat (2) @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, e);
    endtask

    task automatic t_reset;
        rd(4'h0, 32'h00000020, "config reset");
        rd(4'h4, 32'h00000000, "intr reset");
        wr(4'h8, 32'hffffffff);
        rd(4'h8, 32'h00000000, "unmapped");
    endtask

    // The first pulse after a code change may be short, so the second period is judged.
    task automatic t_prescale;
        logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h7, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
        int div [8] = '{1, 2, 8, 16, 32, 64, 128, 256};
        int n;
        for (int i = 0; i < 8; i++) begin
            wr(4'h0, {24'h0, codes[i], 4'h0});
            repeat (2) begin
                n = 0;
                do begin
                    @(posedge clk);
                    n++;
                end while (bus_clk_en !== 1'b1 && n < 600);
            end
            chk("period", n, div[i]);
        end
        wr(4'h0, 32'h00000020);
    endtask

    task automatic t_flags;
        {pll_locked, ext_rdy, fast_rdy, slow_rdy} <= 4'hf;
        repeat (3) @(posedge clk);
        rd(4'h4, 32'h0000001d, "ready flags");
        chk("irq masked", clk_irq, 1'b0);
        wr(4'h4, 32'h00000100);
        chk("irq slow", clk_irq, 1'b1);
        rd(4'h4, 32'h0000011d, "zero clears");
        wr(4'h4, 32'hffffffff);
        rd(4'h4, 32'h00001d00, "clear all");
        chk("irq cleared", clk_irq, 1'b0);
        pll_locked <= 1'b0;
        repeat (2) @(posedge clk);
        pll_locked <= 1'b1;
        repeat (3) @(posedge clk);
        rd(4'h4, 32'h00001d10, "pll relock");
        chk("irq pll", clk_irq, 1'b1);
        wr(4'h4, 32'h00101d00);
        chk("irq pll clr", clk_irq, 1'b0);
    endtask

    task automatic t_select;
        wr(4'h0, 32'h00000021);
        rd(4'h0, 32'h00000025, "ext status");
        wr(4'h0, 32'h00000023);
        rd(4'h0, 32'h00000025, "code 11");
        wr(4'h0, 32'h00000121);
        ext_fail <= 1'b1;
        repeat (3) @(posedge clk);
        rd(4'h0, 32'h00000120, "fail fallback");
        rd(4'h4, 32'h00001d80, "fail flag");
        chk("irq fail", clk_irq, 1'b1);
        wr(4'h4, 32'h00001d00);
        rd(4'h4, 32'h00001d80, "fail sticky");
        wr(4'h4, 32'h00801d00);
        rd(4'h4, 32'h00001d00, "fail clear");
        ext_fail <= 1'b0;
        wr(4'h0, 32'h00000122);
        rd(4'h0, 32'h0000012a, "pll status");
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (2) @(posedge clk);
        chk("wake select", sel, 2'h0);
        rd(4'h0, 32'h00000120, "wake status");
        // Lane 1 is masked off, so the security bit must survive this write.
        avs_byteenable <= 4'h1;
        wr(4'h0, 32'h00000030);
        rd(4'h0, 32'h00000130, "lane 0 only");
        avs_byteenable <= 4'hf;
    endtask

    // A hang past the expected run length ends the run as a failure.
    initial begin
        #100000;
        errors++;
        finish_test;
    end

    initial begin
        rst = 1'b1;
        {avs_read, avs_write, pll_locked, ext_rdy, fast_rdy, slow_rdy, ext_fail, wake} = 8'h00;
        avs_address = 4'h0;
        avs_byteenable = 4'hf;
        avs_writedata = 32'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_prescale;
        t_flags;
        t_select;
        finish_test;
    end
endmodule // test_system_clock_select_and_ready_irq

`default_nettype wire
